// *** core/bpl_pkg.sv ***
package bpl_pkg;
   // Clock and link rate
   localparam int CLK_HZ = 40_000_000;
   localparam int BIT_RATE_BPS = 1200;
   localparam int BIT_CYCLES = CLK_HZ / BIT_RATE_BPS;
   // Low times in sixteenths of a bit period
   localparam int SIXTEENTHS = 16;
   localparam int SYNC_LOW_16THS = 2;
   localparam int ZERO_LOW_16THS = 6;
   localparam int ONE_LOW_16THS = 12;
   localparam int SYNC_DEADLINE_16THS = 3;
   localparam int ZERO_DECIDE_16THS = 4;
   localparam int ONE_DECIDE_16THS = 9;
   localparam int SYNC_LOW_CYCLES = BIT_CYCLES * SYNC_LOW_16THS / SIXTEENTHS;
   localparam int ZERO_LOW_CYCLES = BIT_CYCLES * ZERO_LOW_16THS / SIXTEENTHS;
   localparam int ONE_LOW_CYCLES = BIT_CYCLES * ONE_LOW_16THS / SIXTEENTHS;
   localparam int SYNC_DEADLINE_CYCLES = BIT_CYCLES * SYNC_DEADLINE_16THS / SIXTEENTHS;
   localparam int ZERO_DECIDE_CYCLES =
      (BIT_CYCLES * ZERO_DECIDE_16THS + SIXTEENTHS - 1) / SIXTEENTHS;
   localparam int ONE_DECIDE_CYCLES =
      (BIT_CYCLES * ONE_DECIDE_16THS + SIXTEENTHS - 1) / SIXTEENTHS;
   // Frame layout
   localparam int PAUSE_SYNCS = 3;
   localparam int SLAVE_ADDR_W = 3;
   localparam int REG_ADDR_W = 4;
   localparam int REG_WRITE_BIT = 3;
   localparam int DATA_W = 8;
   localparam int HDR_W = 1 + SLAVE_ADDR_W + REG_ADDR_W;
   localparam int FRAME_BITS = HDR_W + 1 + DATA_W + 1 + 1;
   localparam int SLOTS = PAUSE_SYNCS + FRAME_BITS;
   localparam int FIRST_DATA_SLOT = PAUSE_SYNCS + HDR_W + 1;
   localparam int PARITY2_SLOT = FIRST_DATA_SLOT + DATA_W;
   localparam int ACK_SLOT = PARITY2_SLOT + 1;
   localparam int SLOT_W = 5;
   localparam logic DIR_MASTER = 1'b0;
   localparam logic ACK_GOOD = 1'b0;
   // Response word: write, ack_ok, parity_err, bit_err, data
   localparam int RSP_W = DATA_W + 4;
   localparam int RSP_DEPTH = 2;

   typedef enum logic [0:0] {BPL_IDLE, BPL_SLOT} bpl_state_t;
endpackage

// *** core/bpl_master.sv ***
`timescale 1ns/100ps

////////////////////////////////////////////////////////////////////////////////
// Two-entry response buffer
module bpl_pair_buf #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 2
) (
   // Clock and reset
   input wire logic clock_i,
   input wire logic rst_n_i,
   // Fill side
   input wire logic in_valid_i,
   output logic in_ready_o,
   input wire logic [WIDTH-1:0] in_data_i,
   // Drain side
   output logic out_valid_o,
   input wire logic out_ready_i,
   output logic [WIDTH-1:0] out_data_o
);
   localparam int PTR_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;
   localparam int CNT_W = $clog2(DEPTH + 1);

   logic [WIDTH-1:0] mem [DEPTH];
   logic [PTR_W-1:0] wr_ptr;
   logic [PTR_W-1:0] rd_ptr;
   logic [CNT_W-1:0] count;
   wire push = in_valid_i && in_ready_o;
   wire pop = out_valid_o && out_ready_i;
   wire [PTR_W-1:0] wr_ptr_inc = (wr_ptr == PTR_W'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
   wire [PTR_W-1:0] rd_ptr_inc = (rd_ptr == PTR_W'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;

   assign in_ready_o = (count != CNT_W'(DEPTH));
   assign out_valid_o = (count != '0);
   assign out_data_o = mem[rd_ptr];

   always_ff @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         wr_ptr <= '0;
         rd_ptr <= '0;
         count <= '0;
      end else begin
         if (push) begin
            wr_ptr <= wr_ptr_inc;
         end
         if (pop) begin
            rd_ptr <= rd_ptr_inc;
         end
         if (push && !pop) begin
            count <= count + 1'b1;
         end else if (pop && !push) begin
            count <= count - 1'b1;
         end
      end
   end

   always_ff @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         for (int i = 0; i < DEPTH; i++) begin
            mem[i] <= '0;
         end
      end else if (push) begin
         mem[wr_ptr] <= in_data_i;
      end
   end
endmodule

////////////////////////////////////////////////////////////////////////////////
// Bus master for the pulse-width-coded single-wire link
module bpl_master #(
   parameter int BIT_CYCLES = bpl_pkg::BIT_CYCLES,
   parameter int SYNC_LOW_CYCLES = bpl_pkg::SYNC_LOW_CYCLES,
   parameter int ZERO_LOW_CYCLES = bpl_pkg::ZERO_LOW_CYCLES,
   parameter int ONE_LOW_CYCLES = bpl_pkg::ONE_LOW_CYCLES,
   parameter int SYNC_DEADLINE_CYCLES = bpl_pkg::SYNC_DEADLINE_CYCLES,
   parameter int ZERO_DECIDE_CYCLES = bpl_pkg::ZERO_DECIDE_CYCLES,
   parameter int ONE_DECIDE_CYCLES = bpl_pkg::ONE_DECIDE_CYCLES,
   parameter int CNT_W = 16
) (
   // Clock and reset
   input wire logic clock_i,
   input wire logic rst_n_i,
   // Request
   input wire logic req_valid_i,
   output logic req_ready_o,
   input wire logic req_write_i,
   input wire logic [bpl_pkg::SLAVE_ADDR_W-1:0] req_slave_i,
   input wire logic [bpl_pkg::REG_ADDR_W-2:0] req_reg_i,
   input wire logic [bpl_pkg::DATA_W-1:0] req_data_i,
   // Response
   output logic rsp_valid_o,
   input wire logic rsp_ready_i,
   output logic rsp_write_o,
   output logic rsp_ack_ok_o,
   output logic rsp_parity_err_o,
   output logic rsp_bit_err_o,
   output logic [bpl_pkg::DATA_W-1:0] rsp_data_o,
   // Status
   output logic busy_o,
   // Open-drain line
   input wire logic line_i,
   output logic line_o,
   output logic line_oe_o
);
   logic rst_meta_n;
   logic rst_n;
   bpl_pkg::bpl_state_t state;
   logic [CNT_W-1:0] slot_cnt;
   logic [CNT_W-1:0] low_cnt;
   logic [bpl_pkg::SLOT_W-1:0] slot_idx;
   logic [bpl_pkg::FRAME_BITS-1:0] tx_frame;
   logic is_write;
   logic drive;
   logic late;
   logic [bpl_pkg::DATA_W-1:0] rx_data;
   logic parity_err;
   logic bit_err;
   logic ack_bit;
   logic buf_in_ready;

   ////////////////////////////////////////////////////////////////////////////
   // Reset release
   always_ff @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         rst_meta_n <= 1'b0;
         rst_n <= 1'b0;
      end else begin
         rst_meta_n <= 1'b1;
         rst_n <= rst_meta_n;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Frame assembly and slot decode
   wire take = req_valid_i && req_ready_o;
   wire [bpl_pkg::REG_ADDR_W-1:0] reg_field = {req_write_i, req_reg_i};
   wire [bpl_pkg::HDR_W-1:0] hdr = {bpl_pkg::DIR_MASTER, req_slave_i, reg_field};
   wire hdr_parity = ^hdr;
   wire data_parity = ^req_data_i;
   wire [bpl_pkg::FRAME_BITS-1:0] next_frame =
      {hdr, hdr_parity, req_data_i, data_parity, 1'b0};

   wire in_pause = slot_idx < bpl_pkg::SLOT_W'(bpl_pkg::PAUSE_SYNCS);
   wire [bpl_pkg::SLOT_W-1:0] frame_pos = slot_idx - bpl_pkg::SLOT_W'(bpl_pkg::PAUSE_SYNCS);
   wire [bpl_pkg::SLOT_W-1:0] bit_sel =
      bpl_pkg::SLOT_W'(bpl_pkg::FRAME_BITS - 1) - frame_pos;
   wire tx_bit = tx_frame[bit_sel];
   wire ack_slot = slot_idx == bpl_pkg::SLOT_W'(bpl_pkg::ACK_SLOT);
   wire p2_slot = slot_idx == bpl_pkg::SLOT_W'(bpl_pkg::PARITY2_SLOT);
   wire read_tail = !is_write && slot_idx >= bpl_pkg::SLOT_W'(bpl_pkg::FIRST_DATA_SLOT);
   wire slave_slot = ack_slot || read_tail;

   // Slave bits are opened by a sync-length pull, own bits by code length
   wire [CNT_W-1:0] low_len =
      (in_pause || slave_slot) ? CNT_W'(SYNC_LOW_CYCLES) :
      tx_bit ? CNT_W'(ONE_LOW_CYCLES) : CNT_W'(ZERO_LOW_CYCLES);

   wire slot_end = (state == bpl_pkg::BPL_SLOT) && (slot_cnt == CNT_W'(BIT_CYCLES - 1));
   wire frame_end = slot_end && ack_slot;
   wire drive_end = (slot_cnt == low_len - 1'b1);

   // Bit decode from total low time in the slot
   wire rx_bit = low_cnt >= CNT_W'(ONE_DECIDE_CYCLES);
   wire rx_bad = late || (low_cnt < CNT_W'(ZERO_DECIDE_CYCLES));

   // No take while the internal reset is still held
   assign req_ready_o = rst_n && (state == bpl_pkg::BPL_IDLE) && buf_in_ready;
   assign busy_o = (state == bpl_pkg::BPL_SLOT);
   assign line_o = 1'b0;
   assign line_oe_o = drive;

   ////////////////////////////////////////////////////////////////////////////
   // Slot sequencer
   always_ff @(posedge clock_i or negedge rst_n) begin
      if (!rst_n) begin
         state <= bpl_pkg::BPL_IDLE;
         slot_cnt <= '0;
         slot_idx <= '0;
         drive <= 1'b0;
         tx_frame <= '0;
         is_write <= 1'b0;
      end else begin
         unique case (state)
            bpl_pkg::BPL_IDLE: begin
               if (take) begin
                  state <= bpl_pkg::BPL_SLOT;
                  slot_cnt <= '0;
                  slot_idx <= '0;
                  drive <= 1'b1;
                  tx_frame <= next_frame;
                  is_write <= req_write_i;
               end
            end
            bpl_pkg::BPL_SLOT: begin
               if (slot_end) begin
                  slot_cnt <= '0;
                  if (ack_slot) begin
                     state <= bpl_pkg::BPL_IDLE;
                     drive <= 1'b0;
                  end else begin
                     slot_idx <= slot_idx + 1'b1;
                     drive <= 1'b1;
                  end
               end else begin
                  slot_cnt <= slot_cnt + 1'b1;
                  if (drive_end) begin
                     drive <= 1'b0;
                  end
               end
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Receive side
   always_ff @(posedge clock_i or negedge rst_n) begin
      if (!rst_n) begin
         low_cnt <= '0;
         late <= 1'b0;
         rx_data <= '0;
         parity_err <= 1'b0;
         bit_err <= 1'b0;
         ack_bit <= 1'b1;
      end else if (take) begin
         low_cnt <= '0;
         late <= 1'b0;
         rx_data <= req_data_i;
         parity_err <= 1'b0;
         bit_err <= 1'b0;
         ack_bit <= 1'b1;
      end else if (slot_end) begin
         low_cnt <= '0;
         late <= 1'b0;
         if (slave_slot) begin
            bit_err <= bit_err || rx_bad;
            if (ack_slot) begin
               ack_bit <= rx_bit;
            end else if (p2_slot) begin
               parity_err <= rx_bit != ^rx_data;
            end else begin
               rx_data <= {rx_data[bpl_pkg::DATA_W-2:0], rx_bit};
            end
         end
      end else if (state == bpl_pkg::BPL_SLOT) begin
         if (!line_i) begin
            low_cnt <= low_cnt + 1'b1;
         end
         // Slave must hold the line before the sync window closes
         if (slave_slot && line_i && slot_cnt == CNT_W'(SYNC_DEADLINE_CYCLES)) begin
            late <= 1'b1;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Response buffer
   // Ack slot closes on the push edge, so its bit is taken live
   wire ack_now = ack_slot ? rx_bit : ack_bit;
   wire [bpl_pkg::RSP_W-1:0] rsp_word = {is_write, ack_now == bpl_pkg::ACK_GOOD,
      parity_err, bit_err || (ack_slot && rx_bad), rx_data};
   wire [bpl_pkg::RSP_W-1:0] rsp_out;

   bpl_pair_buf #(
      .WIDTH(bpl_pkg::RSP_W),
      .DEPTH(bpl_pkg::RSP_DEPTH)
   ) u_rsp_buf (
      .clock_i(clock_i),
      .rst_n_i(rst_n),
      .in_valid_i(frame_end),
      .in_ready_o(buf_in_ready),
      .in_data_i(rsp_word),
      .out_valid_o(rsp_valid_o),
      .out_ready_i(rsp_ready_i),
      .out_data_o(rsp_out)
   );

   assign rsp_write_o = rsp_out[bpl_pkg::RSP_W-1];
   assign rsp_ack_ok_o = rsp_out[bpl_pkg::RSP_W-2];
   assign rsp_parity_err_o = rsp_out[bpl_pkg::RSP_W-3];
   assign rsp_bit_err_o = rsp_out[bpl_pkg::RSP_W-4];
   assign rsp_data_o = rsp_out[bpl_pkg::DATA_W-1:0];
endmodule

// *** dv/bpl_master_assertions.sv ***
`timescale 1ns/100ps
module bpl_chk #(parameter int BIT_CYCLES = 160, parameter int SYNC_LOW_CYCLES = 20,
   parameter int ZERO_LOW_CYCLES = 60, parameter int ONE_LOW_CYCLES = 120) (
   input wire logic clock_i,
   input wire logic rst_n_i,
   input wire logic req_valid_i,
   input wire logic req_ready_o,
   input wire logic rsp_valid_o,
   input wire logic rsp_ready_i,
   input wire logic [bpl_pkg::DATA_W-1:0] rsp_data_o,
   input wire logic busy_o,
   input wire logic line_oe_o
);
   int len, gap, np;
   logic oe_q;
   ////////////////////////////////
   // Pull length, pitch, pulses per frame
   always_ff @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         len <= 0;
         gap <= 0;
         np <= 0;
         oe_q <= 1'b0;
      end else begin
         oe_q <= line_oe_o;
         len <= line_oe_o ? len + 1 : 0;
         gap <= (line_oe_o && !oe_q) ? 1 : gap + 1;
         np <= !busy_o ? 0 : (oe_q && !line_oe_o) ? np + 1 : np;
      end
   end
   default clocking cb @(posedge clock_i); endclocking
   default disable iff (!rst_n_i);
   a_idle_released: assert property (!busy_o |-> !line_oe_o) else $error("idle pull");
   a_take_opens: assert property (req_valid_i && req_ready_o |->
      ##[1:2] busy_o && line_oe_o) else $error("no frame");
   a_busy_refuses: assert property (busy_o |-> !req_ready_o) else $error("ready");
   a_pulse_width: assert property (oe_q && !line_oe_o |->
      len inside {SYNC_LOW_CYCLES, ZERO_LOW_CYCLES, ONE_LOW_CYCLES}) else $error("width");
   a_pause_syncs: assert property (oe_q && !line_oe_o && np < 3 |->
      len == SYNC_LOW_CYCLES) else $error("pause");
   a_slot_pitch: assert property (line_oe_o && !oe_q && $past(busy_o) |->
      gap == BIT_CYCLES) else $error("pitch");
   a_frame_pulses: assert property ($fell(busy_o) |-> np == 22 && rsp_valid_o)
      else $error("slots");
   a_rsp_holds: assert property (rsp_valid_o && !rsp_ready_i |=>
      rsp_valid_o && $stable(rsp_data_o)) else $error("rsp lost");
   c_take: cover property (req_valid_i && req_ready_o);
   c_pop: cover property (rsp_valid_o && rsp_ready_i);
   c_full: cover property (rsp_valid_o && !busy_o && !req_ready_o);
endmodule
bind bpl_master bpl_chk #(.BIT_CYCLES(BIT_CYCLES), .SYNC_LOW_CYCLES(SYNC_LOW_CYCLES),
   .ZERO_LOW_CYCLES(ZERO_LOW_CYCLES), .ONE_LOW_CYCLES(ONE_LOW_CYCLES)) chk_u (.*);

// *** dv/bpl_slave_model.sv ***
`timescale 1ns/100ps
module bpl_slave_model #(parameter int ZL = 60, parameter int OL = 120, parameter int OD = 90) (
   input wire logic clock_i,
   input wire logic line_i,
   input wire logic [3:0] lag_i,
   input wire logic [2:0] fault_i,
   output logic pull_o
);
   logic [7:0] regs [8];
   logic [7:0] hdr = 8'h00;
   logic [7:0] wdat, rdat;
   logic p1, ack, tx;
   logic prev = 1'b1;
   int lo = 0;
   int s = 0;
   int len = 0;
   // Serial mode, compare event, fall capture event and start event enabled
   logic [8:0] line_sync_control = 9'h168;
   logic [15:0] tmr = 16'hFF00;
   logic [15:0] cap = 16'h0000;
   logic [15:0] cmp = 16'h0000;
   logic act = 1'b0;
   ////////////////////////////////
   initial begin
      pull_o = 1'b0;
      foreach (regs[i]) regs[i] = 8'h00;
   end
   always @(posedge clock_i) begin
      if (line_sync_control[8] && line_i && !prev) begin
         if (s >= 3 && s <= 10) hdr = {hdr[6:0], lo >= OD};
         if (s == 11) p1 = lo >= OD;
         if (s >= 12 && s <= 19) wdat = {wdat[6:0], lo >= OD};
         if (s == 20) ack = fault_i[0] | hdr[7] | (p1 != ^hdr) |
            (hdr[3] && (lo >= OD) != ^wdat);
         if (s == 20 && hdr[3] && !ack) regs[hdr[2:0]] = wdat;
         s = (s == 21) ? 0 : s + 1;
      end
      if (line_sync_control[6] && !line_i && prev) cap = tmr;
      // Answer only slots the master opened
      if (line_sync_control[3] && !line_i && prev && s >= 12
         && (!hdr[3] || s == 21)) begin
         if (s == 12) rdat = regs[hdr[2:0]];
         tx = s < 20 ? rdat[19 - s] : s == 20 ? ^rdat ^ fault_i[1] : ack;
         len = fault_i[2] ? 0 : tx ? OL : ZL;
         cmp = cap + 16'(lag_i + len);
         act = len != 0;
      end
      // Pull ends on the compare match, across timer wrap too
      if (line_sync_control[5] && tmr == cmp) act = 1'b0;
      lo = line_i ? 0 : lo + 1;
      if (line_i) act = 1'b0;
      pull_o <= act && lo > lag_i;
      prev = line_i;
      if (line_sync_control[6]) tmr = tmr + 16'h0001;
   end
endmodule

// *** dv/tb_bsd_pwm_link_slave_assist.sv ***
`timescale 1ns/100ps
module tb_bsd_pwm_link_slave_assist;
   localparam int B = 160;
   localparam int SL = B * 2 / 16;
   localparam int ZL = B * 6 / 16;
   localparam int OL = B * 12 / 16;
   localparam int DL = B * 3 / 16;
   localparam int ZD = (B * 4 + 15) / 16;
   localparam int OD = (B * 9 + 15) / 16;
   logic clock_i = 1'b0, rst_n_i = 1'b0, req_valid_i = 1'b0, req_write_i = 1'b0;
   logic rsp_ready_i = 1'b0, hold = 1'b1;
   logic [2:0] req_slave_i = 3'h0, req_reg_i = 3'h0, fault = 3'h0;
   logic [7:0] req_data_i = 8'h00, rsp_data_o;
   logic [3:0] lag = 4'h1;
   logic req_ready_o, rsp_valid_o, rsp_write_o, rsp_ack_ok_o, rsp_parity_err_o, rsp_bit_err_o;
   logic busy_o, line_oe_o, line_o, pull;
   logic [11:0] rsp;
   logic [11:0] q[$];
   logic [7:0] m [8] = '{default: 8'h00};
   int fail_count = 0;
   int cmp_count = 0;
   int i;
   // Pulled-up wire
   wire line_i = !((line_oe_o && !line_o) || pull);
   assign rsp = {rsp_write_o, rsp_ack_ok_o, rsp_parity_err_o, rsp_bit_err_o, rsp_data_o};
   ////////////////////////////////
   bpl_master #(.BIT_CYCLES(B), .SYNC_LOW_CYCLES(SL), .ZERO_LOW_CYCLES(ZL),
      .ONE_LOW_CYCLES(OL), .SYNC_DEADLINE_CYCLES(DL), .ZERO_DECIDE_CYCLES(ZD),
      .ONE_DECIDE_CYCLES(OD)) dut_u (.*);
   bpl_slave_model #(.ZL(ZL), .OL(OL), .OD(OD)) slv_u (.clock_i(clock_i), .line_i(line_i),
      .lag_i(lag), .fault_i(fault), .pull_o(pull));
   initial forever #12.5 clock_i = !clock_i;
   ////////////////////////////////
   task automatic chk(input logic [11:0] got, input logic [11:0] exp);
      cmp_count++;
      if (got !== exp) begin
         fail_count++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic final_report;
      $display("compares=%0d mismatches=%0d", cmp_count, fail_count);
      if (fail_count == 0 && cmp_count > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   // One frame; f = {mute, bad parity, bad ack}
   task automatic xfer(input logic w, input logic [2:0] r, input logic [7:0] d,
                       input logic [2:0] f);
      repeat (9000) if (req_ready_o !== 1'b1) @(negedge clock_i);
      fault = f;
      lag = 4'($urandom_range(15, 1));
      req_valid_i = 1'b1;
      req_write_i = w;
      req_slave_i = 3'($urandom);
      req_reg_i = r;
      req_data_i = d;
      q.push_back(f[2] ? 12'h500 : {w, !f[0], f[1], 1'b0, w ? d : m[r]});
      if (w && !f[0]) m[r] = d;
      @(negedge clock_i);
      req_valid_i = 1'b0;
   endtask
   ////////////////////////////////
   always @(negedge clock_i) begin
      rsp_ready_i = !hold && rsp_valid_o === 1'b1 && $urandom_range(2, 0) != 0;
      if (rsp_ready_i) chk(rsp, q.pop_front());
   end
   initial begin
      repeat (25 * 22 * B) @(negedge clock_i);
      fail_count++;
      final_report();
   end
   initial begin
      void'($urandom(88282));
      repeat (12) @(negedge clock_i);
      rst_n_i = 1'b1;
      for (i = 0; i < 16; i++) begin
         if (i == 2) begin
            repeat (22 * B + 4) @(negedge clock_i);
            chk({11'h000, req_ready_o}, 12'h000);
            hold = 1'b0;
         end
         xfer(i < 8, 3'(i), 8'($urandom), 3'h0);
      end
      for (i = 0; i < 3; i++) xfer(i == 0, 3'(i), 8'($urandom), 3'(1 << i));
      repeat (50 * B) if (q.size() != 0) @(negedge clock_i);
      chk(12'(q.size()), 12'h000);
      final_report();
   end
endmodule
